// *** ufd_pkg.sv ***
package ufd_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [31:0] DMA_MODE_ALIAS_OFF = 32'h5000_1194;
   localparam logic [31:0] FIFO_EN_ALIAS_OFF  = 32'h5000_1198;
   localparam logic [31:0] RX_TRIG_ALIAS_OFF  = 32'h5000_119c;
   localparam logic [31:0] FIFO_CTRL_OFF      = 32'h5000_11b4;
   localparam logic [31:0] IRQ_STATUS_OFF     = 32'h5000_11b8;
   localparam logic [31:0] IRQ_MASK_OFF       = 32'h5000_11bc;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int FCR_FIFO_EN_BIT  = 0;
   localparam int FCR_RX_RST_BIT   = 1;
   localparam int FCR_TX_RST_BIT   = 2;
   localparam int FCR_DMA_MODE_BIT = 3;
   localparam int FCR_RX_TRIG_LSB  = 6;
   localparam int FCR_RX_TRIG_MSB  = 7;
   localparam int IRQ_RX_AVAIL_BIT = 0;
   localparam int IRQ_FIFO_RST_BIT = 1;
   localparam int IRQ_WIDTH        = 2;
   localparam logic [1:0] RX_TRIG_RESET  = 2'h0;
   localparam logic       DMA_MODE_RESET = 1'h0;
   localparam logic       FIFO_EN_RESET  = 1'h0;

   // ************************************************************
   // Encodings
   // ************************************************************
   localparam logic [1:0] RX_TRIG_ONE  = 2'h0;
   localparam logic [1:0] RX_TRIG_HALF = 2'h1;
   localparam logic [1:0] RX_TRIG_HALF2 = 2'h2;
   localparam logic [1:0] RX_TRIG_NEAR = 2'h3;
   localparam int RX_TRIG_NEAR_GAP = 2;
   localparam logic DMA_MODE_0 = 1'h0;
   localparam logic DMA_MODE_1 = 1'h1;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ufd_bus_req_type;

   typedef struct packed {
      logic [1:0] rx_trig;
      logic       dma_mode;
      logic       fifo_en;
   } ufd_ctrl_type;

endpackage

// *** ufd_ctrl.sv ***
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
// Functional notes
// RULE1 - One-bit DMA mode alias writes only the DMA mode control bit.
// RULE2 - DMA mode 0 or 1 selects request signalling for both DMA outputs.
// RULE3 - One-bit FIFO enable alias writes only the enable control bit.
// RULE4 - Enable set turns on both FIFOs; clear means unbuffered operation.
// RULE5 - Enable falling from one to zero resets both FIFO control parts.
// RULE6 - Two-bit receive trigger alias writes only the trigger field.
// RULE7 - Receive trigger sets fill level raising the data-available interrupt.
// RULE8 - In DMA mode 1 the trigger level also asserts receive DMA request.
// RULE9 - Codes: 00 one char, 01 and 10 half full, 11 two short.
// RULE10 - Aliases and control register share one storage element each.
module ufd_ctrl #(
   parameter int DEPTH = 16,
   parameter int LW    = $clog2(DEPTH) + 1
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // Register port
   input  wire ufd_pkg::ufd_bus_req_type bus_req,
   output logic [15:0]                 rdata,
   // FIFO status from the datapath
   input  wire logic [LW-1:0]          rx_level,
   input  wire logic [LW-1:0]          tx_level,
   // FIFO control to the datapath
   output ufd_pkg::ufd_ctrl_type       ctrl,
   output logic                        tx_fifo_reset,
   output logic                        rx_fifo_reset,
   output logic                        rx_data_avail,
   // DMA requests
   output logic                        dma_tx_req_n,
   output logic                        dma_rx_req_n,
   // Interrupt
   output logic                        irq
);

   // ************************************************************
   // State
   // ************************************************************
   ufd_pkg::ufd_ctrl_type       next_ctrl;
   logic                        next_tx_fifo_reset;
   logic                        next_rx_fifo_reset;
   logic                        next_rx_data_avail;
   logic                        next_dma_tx_req_n;
   logic                        next_dma_rx_req_n;
   logic [15:0]                 next_rdata;
   logic [ufd_pkg::IRQ_WIDTH-1:0] irq_status;
   logic [ufd_pkg::IRQ_WIDTH-1:0] next_irq_status;
   logic [ufd_pkg::IRQ_WIDTH-1:0] irq_mask;
   logic [ufd_pkg::IRQ_WIDTH-1:0] next_irq_mask;
   logic [LW-1:0]               rx_thresh;
   logic                        rx_at_thresh;
   logic                        fifo_disable;
   logic                        wr_dma;
   logic                        wr_fe;
   logic                        wr_trig;
   logic                        wr_fcr;
   logic [15:0]                 fcr_view;
   logic [ufd_pkg::IRQ_WIDTH-1:0] irq_events;

   assign wr_dma  = bus_req.wr && bus_req.addr == ufd_pkg::DMA_MODE_ALIAS_OFF;
   assign wr_fe   = bus_req.wr && bus_req.addr == ufd_pkg::FIFO_EN_ALIAS_OFF;
   assign wr_trig = bus_req.wr && bus_req.addr == ufd_pkg::RX_TRIG_ALIAS_OFF;
   assign wr_fcr  = bus_req.wr && bus_req.addr == ufd_pkg::FIFO_CTRL_OFF;

   // ************************************************************
   // Trigger decode
   // ************************************************************
   always_comb begin
      case (ctrl.rx_trig)
         ufd_pkg::RX_TRIG_ONE:   rx_thresh = LW'(1);               // RULE9
         ufd_pkg::RX_TRIG_HALF,
         ufd_pkg::RX_TRIG_HALF2: rx_thresh = LW'(DEPTH / 2);       // RULE9
         ufd_pkg::RX_TRIG_NEAR:
            rx_thresh = LW'(DEPTH - ufd_pkg::RX_TRIG_NEAR_GAP);    // RULE9
         default:                rx_thresh = LW'(1);
      endcase
   end

   // Unbuffered operation behaves as a one-entry holding register
   assign rx_at_thresh = ctrl.fifo_en ? (rx_level >= rx_thresh)    // RULE4
                                      : (rx_level != '0);

   // ************************************************************
   // Control storage shared by aliases and control register
   // ************************************************************
   always_comb begin
      next_ctrl = ctrl;
      if (wr_dma) begin
         next_ctrl.dma_mode = bus_req.wdata[0];                    // RULE1
      end
      if (wr_fe) begin
         next_ctrl.fifo_en = bus_req.wdata[0];                     // RULE3
      end
      if (wr_trig) begin
         next_ctrl.rx_trig = bus_req.wdata[1:0];                   // RULE6
      end
      if (wr_fcr) begin
         next_ctrl.fifo_en  = bus_req.wdata[ufd_pkg::FCR_FIFO_EN_BIT]; // RULE10
         next_ctrl.dma_mode = bus_req.wdata[ufd_pkg::FCR_DMA_MODE_BIT];
         next_ctrl.rx_trig  =
            bus_req.wdata[ufd_pkg::FCR_RX_TRIG_MSB:ufd_pkg::FCR_RX_TRIG_LSB];
      end
   end

   assign fifo_disable = ctrl.fifo_en && !next_ctrl.fifo_en;

   // ************************************************************
   // FIFO resets, data available and DMA requests
   // ************************************************************
   always_comb begin
      next_tx_fifo_reset = fifo_disable ||                         // RULE5
         (wr_fcr && bus_req.wdata[ufd_pkg::FCR_TX_RST_BIT]);
      next_rx_fifo_reset = fifo_disable ||                         // RULE5
         (wr_fcr && bus_req.wdata[ufd_pkg::FCR_RX_RST_BIT]);
      next_rx_data_avail = rx_at_thresh;                           // RULE7
      if (ctrl.dma_mode == ufd_pkg::DMA_MODE_1) begin              // RULE2
         next_dma_rx_req_n = !rx_at_thresh;                        // RULE8
         next_dma_tx_req_n = ctrl.fifo_en ? (tx_level >= LW'(DEPTH))
                                          : (tx_level != '0);
      end else begin
         next_dma_rx_req_n = (rx_level == '0);                     // RULE2
         next_dma_tx_req_n = (tx_level != '0);
      end
   end

   // ************************************************************
   // Interrupts and read port
   // ************************************************************
   assign irq_events = {next_rx_fifo_reset, rx_at_thresh && !rx_data_avail};
   assign fcr_view   = 16'(ctrl.fifo_en) << ufd_pkg::FCR_FIFO_EN_BIT
                     | 16'(ctrl.dma_mode) << ufd_pkg::FCR_DMA_MODE_BIT
                     | 16'(ctrl.rx_trig) << ufd_pkg::FCR_RX_TRIG_LSB;

   always_comb begin
      next_irq_mask   = irq_mask;
      next_irq_status = irq_status;
      next_rdata      = 16'h0000;
      if (bus_req.wr && bus_req.addr == ufd_pkg::IRQ_STATUS_OFF) begin
         next_irq_status = irq_status & ~bus_req.wdata[ufd_pkg::IRQ_WIDTH-1:0];
      end
      if (bus_req.wr && bus_req.addr == ufd_pkg::IRQ_MASK_OFF) begin
         next_irq_mask = bus_req.wdata[ufd_pkg::IRQ_WIDTH-1:0];
      end
      // Set wins over a clear in the same cycle
      next_irq_status = next_irq_status | irq_events;
      if (bus_req.rd) begin
         case (bus_req.addr)
            ufd_pkg::DMA_MODE_ALIAS_OFF: next_rdata = 16'(ctrl.dma_mode);
            ufd_pkg::FIFO_EN_ALIAS_OFF:  next_rdata = 16'(ctrl.fifo_en);
            ufd_pkg::RX_TRIG_ALIAS_OFF:  next_rdata = 16'(ctrl.rx_trig);
            ufd_pkg::FIFO_CTRL_OFF:      next_rdata = fcr_view;    // RULE10
            ufd_pkg::IRQ_STATUS_OFF:     next_rdata = 16'(irq_status);
            ufd_pkg::IRQ_MASK_OFF:       next_rdata = 16'(irq_mask);
            default:                     next_rdata = 16'h0000;
         endcase
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl.fifo_en  <= ufd_pkg::FIFO_EN_RESET;
         ctrl.dma_mode <= ufd_pkg::DMA_MODE_RESET;
         ctrl.rx_trig  <= ufd_pkg::RX_TRIG_RESET;
         tx_fifo_reset <= 1'h0;
         rx_fifo_reset <= 1'h0;
         rx_data_avail <= 1'h0;
         dma_tx_req_n  <= 1'h1;
         dma_rx_req_n  <= 1'h1;
         irq_status    <= '0;
         irq_mask      <= '0;
         rdata         <= 16'h0000;
      end else begin
         ctrl          <= next_ctrl;
         tx_fifo_reset <= next_tx_fifo_reset;
         rx_fifo_reset <= next_rx_fifo_reset;
         rx_data_avail <= next_rx_data_avail;
         dma_tx_req_n  <= next_dma_tx_req_n;
         dma_rx_req_n  <= next_dma_rx_req_n;
         irq_status    <= next_irq_status;
         irq_mask      <= next_irq_mask;
         rdata         <= next_rdata;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   dma_alias_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
      wr_dma && !wr_fcr |=> ctrl.dma_mode == $past(bus_req.wdata[0])
         && ctrl.fifo_en == $past(ctrl.fifo_en)
         && ctrl.rx_trig == $past(ctrl.rx_trig))
      else $error("dma mode alias write wrong");

   mode0_rx_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
      ctrl.dma_mode == ufd_pkg::DMA_MODE_0 && rx_level != '0
         |=> !dma_rx_req_n)
      else $error("mode 0 rx request missing");

   fe_alias_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
      wr_fe && !wr_fcr |=> ctrl.fifo_en == $past(bus_req.wdata[0])
         && ctrl.dma_mode == $past(ctrl.dma_mode)
         && ctrl.rx_trig == $past(ctrl.rx_trig))
      else $error("fifo enable alias write wrong");

   unbuf_avail_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
      !ctrl.fifo_en && rx_level != '0 |=> rx_data_avail)
      else $error("unbuffered data not flagged");

   dis_reset_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
      $fell(ctrl.fifo_en) |-> tx_fifo_reset && rx_fifo_reset)
      else $error("fifo disable did not reset fifos");

   trig_alias_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
      wr_trig && !wr_fcr |=> ctrl.rx_trig == $past(bus_req.wdata[1:0])
         && ctrl.fifo_en == $past(ctrl.fifo_en))
      else $error("rx trigger alias write wrong");

   rx_avail_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
      ctrl.fifo_en && rx_level >= rx_thresh |=> rx_data_avail)
      else $error("data available not raised at trigger");

   mode1_rx_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
      ctrl.dma_mode == ufd_pkg::DMA_MODE_1 && ctrl.fifo_en
         |=> dma_rx_req_n == ($past(rx_level) < $past(rx_thresh)))
      else $error("mode 1 rx request not on trigger");

   trig_code_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
      (ctrl.rx_trig == ufd_pkg::RX_TRIG_NEAR
         && rx_thresh == LW'(DEPTH - ufd_pkg::RX_TRIG_NEAR_GAP))
      || (ctrl.rx_trig == ufd_pkg::RX_TRIG_ONE && rx_thresh == LW'(1))
      || (ctrl.rx_trig[1] ^ ctrl.rx_trig[0]
         && rx_thresh == LW'(DEPTH / 2)))
      else $error("rx trigger decode wrong");

   shared_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
      wr_dma && !wr_fcr ##1 bus_req.rd && bus_req.addr == ufd_pkg::FIFO_CTRL_OFF
         |=> rdata[ufd_pkg::FCR_DMA_MODE_BIT] == ctrl.dma_mode)
      else $error("alias not visible in control register");

   fcr_txrst_a: assert property (@(posedge clk) disable iff (!arst_n)
      wr_fcr && bus_req.wdata[ufd_pkg::FCR_TX_RST_BIT] |=> tx_fifo_reset)
      else $error("control register tx reset missing");

   fcr_rxrst_a: assert property (@(posedge clk) disable iff (!arst_n)
      wr_fcr && bus_req.wdata[ufd_pkg::FCR_RX_RST_BIT] |=> rx_fifo_reset)
      else $error("control register rx reset missing");

   fe_status_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
      fifo_disable |=> irq_status[ufd_pkg::IRQ_FIFO_RST_BIT])
      else $error("fifo reset status not set");

   avail_set_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
      rx_at_thresh && !rx_data_avail
         |=> irq_status[ufd_pkg::IRQ_RX_AVAIL_BIT])
      else $error("data available status not set");

   rd_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
      !bus_req.rd |=> rdata == 16'h0000)
      else $error("read data not zero outside read");

   dma_rd_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
      bus_req.rd && bus_req.addr == ufd_pkg::DMA_MODE_ALIAS_OFF
         |=> rdata == 16'($past(ctrl.dma_mode)))
      else $error("dma mode alias read wrong");

   fe_rd_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
      bus_req.rd && bus_req.addr == ufd_pkg::FIFO_EN_ALIAS_OFF
         |=> rdata == 16'($past(ctrl.fifo_en)))
      else $error("fifo enable alias read wrong");

   trig_rd_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
      bus_req.rd && bus_req.addr == ufd_pkg::RX_TRIG_ALIAS_OFF
         |=> rdata == 16'($past(ctrl.rx_trig)))
      else $error("rx trigger alias read wrong");

   mode0_tx_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
      ctrl.dma_mode == ufd_pkg::DMA_MODE_0 && tx_level == '0
         |=> !dma_tx_req_n)
      else $error("mode 0 tx request missing");

   mode1_tx_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
      ctrl.dma_mode == ufd_pkg::DMA_MODE_1 && ctrl.fifo_en
         && tx_level < LW'(DEPTH) |=> !dma_tx_req_n)
      else $error("mode 1 tx request missing");

   mode1_off_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
      ctrl.dma_mode == ufd_pkg::DMA_MODE_1 && !ctrl.fifo_en
         |=> dma_rx_req_n == ($past(rx_level) == '0))
      else $error("unbuffered mode 1 rx request wrong");

   mask_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
      bus_req.wr && bus_req.addr == ufd_pkg::IRQ_MASK_OFF
         |=> irq_mask == $past(bus_req.wdata[ufd_pkg::IRQ_WIDTH-1:0]))
      else $error("interrupt mask write wrong");

   status_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
      bus_req.wr && bus_req.addr == ufd_pkg::IRQ_STATUS_OFF
         && irq_events == '0
         |=> (irq_status
            & $past(bus_req.wdata[ufd_pkg::IRQ_WIDTH-1:0])) == '0)
      else $error("interrupt status clear failed");

endmodule

// *** ufd_dma_model.sv ***
`timescale 1ns/1ns
// ************************************************************
// DMA controller side: counts request cycles
// ************************************************************
module ufd_dma_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Requests from the block
   input  wire logic        dma_tx_req_n,
   input  wire logic        dma_rx_req_n,
   // Counts seen
   output logic [15:0]      rx_count,
   output logic [15:0]      tx_count
);
   logic [15:0] next_rx_count;
   logic [15:0] next_tx_count;

   always_comb begin
      next_rx_count = rx_count + {15'h0, ~dma_rx_req_n};
      next_tx_count = tx_count + {15'h0, ~dma_tx_req_n};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_count <= 16'h0;
         tx_count <= 16'h0;
      end else begin
         rx_count <= next_rx_count;
         tx_count <= next_tx_count;
      end
   end
endmodule

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
   localparam int DEPTH = 16;
   logic                     clk;
   logic                     arst_n;
   ufd_pkg::ufd_bus_req_type bus_req;
   logic [15:0]              rdata;
   logic [4:0]               rx_level;
   logic [4:0]               tx_level;
   ufd_pkg::ufd_ctrl_type    ctrl;
   logic                     tx_fifo_reset;
   logic                     rx_fifo_reset;
   logic                     rx_data_avail;
   logic                     dma_tx_req_n;
   logic                     dma_rx_req_n;
   logic                     irq;
   logic [15:0]              rx_count;
   logic [15:0]              tx_count;
   int                       err_count;
   int                       compares;

   ufd_ctrl #(.DEPTH(DEPTH)) ufd_ctrl_inst (.clk(clk), .arst_n(arst_n),
      .bus_req(bus_req), .rdata(rdata), .rx_level(rx_level),
      .tx_level(tx_level), .ctrl(ctrl), .tx_fifo_reset(tx_fifo_reset),
      .rx_fifo_reset(rx_fifo_reset), .rx_data_avail(rx_data_avail),
      .dma_tx_req_n(dma_tx_req_n), .dma_rx_req_n(dma_rx_req_n), .irq(irq));
   ufd_dma_model ufd_dma_model_inst (.clk(clk), .arst_n(arst_n),
      .dma_tx_req_n(dma_tx_req_n), .dma_rx_req_n(dma_rx_req_n),
      .rx_count(rx_count), .tx_count(tx_count));

   always #20 clk = ~clk;

   // ************************************************************
   // Bus cycles and compares
   // ************************************************************
   task automatic chk_reg(input string n, input logic [15:0] e,
                          input logic [15:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input string n, input logic [31:0] a,
                         input logic [15:0] e);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 chk_reg(n, e, rdata);
   endtask
   task automatic wr_rd(input string n, input logic [31:0] a,
                        input logic [15:0] d, input logic [31:0] ra,
                        input logic [15:0] e);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req <= '{addr: ra, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 chk_reg(n, e, rdata);
   endtask
   task automatic set_lvl(input int r, input int t);
      @(posedge clk);
      rx_level <= 5'(r);
      tx_level <= 5'(t);
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_alias;
      wr(ufd_pkg::FIFO_CTRL_OFF, 16'h00c7);
      rd_chk("ctrl", ufd_pkg::FIFO_CTRL_OFF, 16'h00c1);
      wr(ufd_pkg::DMA_MODE_ALIAS_OFF, 16'h0001);
      rd_chk("ctrl", ufd_pkg::FIFO_CTRL_OFF, 16'h00c9);
      rd_chk("dma_alias", ufd_pkg::DMA_MODE_ALIAS_OFF, 16'h0001);
      wr(ufd_pkg::RX_TRIG_ALIAS_OFF, 16'h0001);
      rd_chk("ctrl", ufd_pkg::FIFO_CTRL_OFF, 16'h0049);
      rd_chk("trig_alias", ufd_pkg::RX_TRIG_ALIAS_OFF, 16'h0001);
      wr(ufd_pkg::FIFO_EN_ALIAS_OFF, 16'h0000);
      chk_bit("tx_fifo_reset", 1'b1, tx_fifo_reset);
      chk_bit("rx_fifo_reset", 1'b1, rx_fifo_reset);
      rd_chk("ctrl", ufd_pkg::FIFO_CTRL_OFF, 16'h0048);
      rd_chk("en_alias", ufd_pkg::FIFO_EN_ALIAS_OFF, 16'h0000);
      rd_chk("status", ufd_pkg::IRQ_STATUS_OFF, 16'h0002);
      wr(32'h5000_11c4, 16'hffff);
      rd_chk("unmapped", 32'h5000_11c4, 16'h0000);
      wr_rd("ctrl", ufd_pkg::DMA_MODE_ALIAS_OFF, 16'h0000,
            ufd_pkg::FIFO_CTRL_OFF, 16'h0040);
   endtask
   task automatic t_thresh;
      int th;
      wr(ufd_pkg::FIFO_CTRL_OFF, 16'h0009);
      for (int c = 0; c < 4; c++) begin
         th = (c == 0) ? 1 : (c == 3) ? DEPTH - 2 : DEPTH / 2;
         wr(ufd_pkg::RX_TRIG_ALIAS_OFF, 16'(c));
         set_lvl(th - 1, 0);
         chk_bit("rx_data_avail", 1'b0, rx_data_avail);
         chk_bit("dma_rx_req_n", 1'b1, dma_rx_req_n);
         set_lvl(th, 0);
         chk_bit("rx_data_avail", 1'b1, rx_data_avail);
         chk_bit("dma_rx_req_n", 1'b0, dma_rx_req_n);
      end
      set_lvl(0, DEPTH);
      chk_bit("dma_tx_req_n", 1'b1, dma_tx_req_n);
      set_lvl(0, 3);
      chk_bit("dma_tx_req_n", 1'b0, dma_tx_req_n);
   endtask
   task automatic t_mode0;
      wr(ufd_pkg::FIFO_CTRL_OFF, 16'h00c1);
      set_lvl(1, 0);
      chk_bit("dma_rx_req_n", 1'b0, dma_rx_req_n);
      chk_bit("dma_tx_req_n", 1'b0, dma_tx_req_n);
      chk_bit("rx_data_avail", 1'b0, rx_data_avail);
      set_lvl(1, 3);
      chk_bit("dma_tx_req_n", 1'b1, dma_tx_req_n);
      wr(ufd_pkg::FIFO_EN_ALIAS_OFF, 16'h0000);
      set_lvl(1, 0);
      chk_bit("rx_data_avail", 1'b1, rx_data_avail);
      chk_bit("fifo_en", 1'b0, ctrl.fifo_en);
   endtask
   task automatic t_irq;
      wr(ufd_pkg::FIFO_CTRL_OFF, 16'h0001);
      set_lvl(0, 0);
      wr(ufd_pkg::IRQ_STATUS_OFF, 16'h0003);
      wr(ufd_pkg::IRQ_MASK_OFF, 16'h0001);
      chk_bit("irq", 1'b0, irq);
      set_lvl(1, 0);
      chk_bit("irq", 1'b1, irq);
      rd_chk("status", ufd_pkg::IRQ_STATUS_OFF, 16'h0001);
      wr(ufd_pkg::IRQ_MASK_OFF, 16'h0000);
      chk_bit("irq", 1'b0, irq);
      wr(ufd_pkg::IRQ_MASK_OFF, 16'h0001);
      chk_bit("irq", 1'b1, irq);
      wr(ufd_pkg::IRQ_STATUS_OFF, 16'h0001);
      chk_bit("irq", 1'b0, irq);
      chk_bit("dma_seen", 1'b1, |rx_count);
      chk_bit("dma_tx_seen", 1'b1, |tx_count);
   endtask
   task automatic t_reset;
      wr(ufd_pkg::FIFO_CTRL_OFF, 16'h00c9);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk_bit("dma_tx_req_n", 1'b1, dma_tx_req_n);
      chk_bit("fifo_en", 1'b0, ctrl.fifo_en);
      chk_bit("irq", 1'b0, irq);
      rd_chk("ctrl", ufd_pkg::FIFO_CTRL_OFF, 16'h0000);
      rd_chk("dma_alias", ufd_pkg::DMA_MODE_ALIAS_OFF, 16'h0000);
   endtask

   task automatic tally_and_finish;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      bus_req = '0;
      rx_level = 5'h0;
      tx_level = 5'h0;
      err_count = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      chk_bit("dma_rx_req_n", 1'b1, dma_rx_req_n);
      chk_bit("irq", 1'b0, irq);
      arst_n <= 1'b1;
      rd_chk("dma_alias", ufd_pkg::DMA_MODE_ALIAS_OFF, 16'h0000);
      rd_chk("en_alias", ufd_pkg::FIFO_EN_ALIAS_OFF, 16'h0000);
      rd_chk("trig_alias", ufd_pkg::RX_TRIG_ALIAS_OFF, 16'h0000);
      t_alias();
      t_thresh();
      t_mode0();
      t_irq();
      t_reset();
      tally_and_finish();
   end

   initial begin
      #400000;
      err_count++;
      tally_and_finish();
   end
endmodule
